// ### pkg/aea_pkg.sv
/*
 package for the active energy accumulator: register offsets, field positions,
 reset values and timing counts.
 assumes a 200 MHz metering core clock and one register port on that clock.
*/
// Functional notes
// R01 - full scale, unity gain: one energy pulse per channel every 4.83 us.
// R02 - energy registers are 24-bit signed, 0x7FFFFF largest before overflow.
// R03 - line-cycle mode sums energy between voltage zero crossings, both channels.
// R04 - line-cycle mode off after reset; each channel has its own enable bit.
// R05 - half-cycle count register sets period length, up to 65535 half cycles.
// R06 - one half-cycle count governs both channels' periods together.
// R07 - period end updates both energy registers and sets the done flag together.
// R08 - done flag with its enable bit set drives the low-active interrupt.
// R09 - a new period starts right after each one while enables stay set.
// R10 - in line-cycle mode energy registers hold until the next period end.
// R11 - line-cycle mode with clear-on-read: a read zeroes until next period end.
// R12 - count written mid-period takes effect only for the following period.
// R13 - software should discard the first result after enabling line-cycle mode.
// R14 - after reset accumulation is signed.
// R15 - mode 01 accumulates only positive power, negative power ignored.
// R16 - mode 10 accumulates absolute power; no-load energy still excluded.
// R17 - positive-only and absolute modes affect energy registers and pulse pins.
// R18 - positive-only or absolute mode disables reverse-power indication.
// R19 - overflow wraps to 0x800000 counting up; underflow to 0x7FFFFF down.
// R20 - clear-on-read default on; clearing bit 6 of line-cycle config turns it off.
// R21 - 48-bit first stage sums power every 143 us; threshold yields pulses.
// R22 - mode 00 is signed; each channel's mode field is independent.
package aea_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 24;
    localparam int ACC_W = 48;

    localparam logic [9:0] OFS_LINE_CYCLE_CONFIG = 10'h004;
    localparam logic [9:0] OFS_HALF_CYCLE_COUNT = 10'h101;
    localparam logic [9:0] OFS_ACCUM_MODE_SELECT = 10'h201;
    localparam logic [9:0] OFS_ENERGY_A = 10'h21E;
    localparam logic [9:0] OFS_ENERGY_B = 10'h21F;
    localparam logic [9:0] OFS_IRQ_ENABLE_A = 10'h22C;
    localparam logic [9:0] OFS_IRQ_STATUS_A = 10'h22D;

    localparam int CFG_EN_A_BIT = 0;
    localparam int CFG_EN_B_BIT = 1;
    localparam int CFG_CLR_ON_READ_BIT = 6;
    localparam logic [7:0] CFG_RESET = 8'h40;
    localparam logic [15:0] HCC_RESET = 16'h00FF;
    localparam int MODE_A_LSB = 0;
    localparam int MODE_B_LSB = 2;
    localparam int SIGN_A_BIT = 18;
    localparam int SIGN_B_BIT = 19;
    localparam logic [3:0] MODE_RESET = 4'h0;
    localparam int PERIOD_DONE_BIT = 18;
    localparam logic [23:0] IRQ_EN_RESET = 24'h000000;

    localparam logic [1:0] MODE_SIGNED = 2'h0;
    localparam logic [1:0] MODE_POSITIVE = 2'h1;
    localparam logic [1:0] MODE_ABSOLUTE = 2'h2;

    localparam logic [23:0] GAIN_UNITY = 24'h400000;
    localparam int GAIN_SHIFT = 22;
    localparam logic [23:0] ENERGY_MAX = 24'h7FFFFF;
    localparam logic [23:0] ENERGY_MIN = 24'h800000;

    localparam int CLK_PERIOD_PS = 5000;
    localparam int UPDATE_PERIOD_US = 143;
    localparam int UPDATE_CYCLES = UPDATE_PERIOD_US * 1000000 / CLK_PERIOD_PS;
    localparam int PULSE_PERIOD_NS = 4830;
    localparam int PULSE_CYCLES = PULSE_PERIOD_NS * 1000 / CLK_PERIOD_PS;
    localparam int FULL_SCALE_POWER = 4862401;
    // full-scale power added per update, spread to one pulse per pulse period
    localparam logic [47:0] ACC_THRESHOLD =
        48'(64'(FULL_SCALE_POWER) * 64'(PULSE_CYCLES) / 64'(UPDATE_CYCLES));
endpackage

// ### logic/aea_chan.sv
/*
 one channel's first accumulation stage: gain, accumulation mode, 48-bit sum,
 threshold pulses toward the energy register.
 assumes power and gain come from logic on the same clock.
*/
`timescale 1ns/1ps
module aea_chan #(
    parameter logic [47:0] THRESHOLD = aea_pkg::ACC_THRESHOLD
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic tick,
    input wire logic signed [23:0] power,
    input wire logic signed [23:0] gain,
    input wire logic [1:0] mode,
    input wire logic no_load,
    output logic pulse_up,
    output logic pulse_dn,
    output logic power_neg
);
    logic signed [47:0] prod;
    logic signed [47:0] scaled;
    logic signed [47:0] contrib;
    logic signed [47:0] acc_r;
    logic signed [47:0] acc_nxt;
    logic signed [47:0] thr;
    logic up_nxt;
    logic dn_nxt;

    assign thr = $signed(THRESHOLD);
    assign prod = 48'(power) * 48'(gain);
    assign scaled = prod >>> aea_pkg::GAIN_SHIFT; // R01

    always_comb begin
        case (mode)
            aea_pkg::MODE_POSITIVE: contrib = (scaled < 0) ? 48'sh0 : scaled; // R15
            aea_pkg::MODE_ABSOLUTE: contrib = (scaled < 0) ? -scaled : scaled; // R16
            default: contrib = scaled; // R22
        endcase
        if (no_load) begin
            contrib = 48'sh0; // R16
        end
    end

    // one pulse per clock at most; the rate is far below the clock
    always_comb begin
        acc_nxt = acc_r + (tick ? contrib : 48'sh0); // R21
        up_nxt = 1'b0;
        dn_nxt = 1'b0;
        if (acc_r >= thr) begin
            acc_nxt = acc_nxt - thr; // R21
            up_nxt = 1'b1;
        end else if (acc_r <= -thr) begin
            acc_nxt = acc_nxt + thr;
            dn_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            acc_r <= 48'sh0;
            pulse_up <= 1'b0;
            pulse_dn <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            pulse_up <= up_nxt;
            pulse_dn <= dn_nxt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            power_neg <= 1'b0;
        end else if (tick) begin
            power_neg <= scaled < 0;
        end
    end

    property p_pos_no_down;
        @(posedge clock) disable iff (rst)
        (mode == aea_pkg::MODE_POSITIVE) && tick |-> contrib >= 0;
    endproperty
    a_pos_no_down: assert property (p_pos_no_down) else $error("negative contribution in positive mode"); // R15

    property p_abs_magnitude;
        @(posedge clock) disable iff (rst)
        (mode == aea_pkg::MODE_ABSOLUTE) && !no_load && tick |=> acc_r == $past(acc_r) + (($past(scaled) < 0)
            ? -$past(scaled) : $past(scaled)) - ($past(up_nxt) ? thr : 48'sh0) + ($past(dn_nxt) ? thr : 48'sh0);
    endproperty
    a_abs_magnitude: assert property (p_abs_magnitude) else $error("absolute mode sum wrong"); // R16

    property p_pulse_on_threshold;
        @(posedge clock) disable iff (rst)
        acc_r >= thr |=> pulse_up && !pulse_dn;
    endproperty
    a_pulse_on_threshold: assert property (p_pulse_on_threshold) else $error("missing pulse at threshold"); // R21
endmodule

// ### logic/aea_top.sv
/*
 active energy accumulator: two channels, free-running or line-cycle mode,
 register port, period-done interrupt and energy pulse pins.
 assumes power samples, zero-crossing pulses and register strobes all come from
 logic on this clock; the serial host interface sits outside.
*/
`timescale 1ns/1ps
module aea_top #(
    parameter int UPDATE_CYCLES = aea_pkg::UPDATE_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [9:0] reg_addr,
    input wire logic [23:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [23:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic zx_pulse,
    input wire logic signed [23:0] power_a,
    input wire logic signed [23:0] power_b,
    input wire logic signed [23:0] chan_a_power_gain,
    input wire logic signed [23:0] chan_b_power_gain,
    input wire logic no_load_a,
    input wire logic no_load_b,
    output logic irq_n,
    output logic [1:0] energy_pulse_out,
    output logic [1:0] reverse_power_en
);
    logic [7:0] line_cycle_config_r;
    logic [15:0] half_cycle_count_r;
    logic [3:0] accum_mode_r;
    logic [23:0] interrupt_enable_a_r;
    logic period_done_flag_r;
    logic [15:0] active_count_r;
    logic [15:0] zx_count_r;
    logic [15:0] zx_count_nxt;
    logic [31:0] tick_cnt_r;
    logic tick;
    logic period_end;
    logic [1:0] cyc_en;
    logic any_en;
    logic clr_on_read;
    logic [1:0] pulse_up;
    logic [1:0] pulse_dn;
    logic [1:0] power_neg;
    logic [1:0] rd_energy;
    logic [23:0] live_r [2];
    logic [23:0] result_r [2];
    logic [23:0] delta [2];
    logic [23:0] rdata_nxt;

    assign cyc_en = {line_cycle_config_r[aea_pkg::CFG_EN_B_BIT], line_cycle_config_r[aea_pkg::CFG_EN_A_BIT]};
    assign any_en = |cyc_en;
    assign clr_on_read = line_cycle_config_r[aea_pkg::CFG_CLR_ON_READ_BIT];
    assign rd_energy[0] = reg_rd && (reg_addr == aea_pkg::OFS_ENERGY_A);
    assign rd_energy[1] = reg_rd && (reg_addr == aea_pkg::OFS_ENERGY_B);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            line_cycle_config_r <= aea_pkg::CFG_RESET; // R04 R20
            half_cycle_count_r <= aea_pkg::HCC_RESET;
            accum_mode_r <= aea_pkg::MODE_RESET; // R14
            interrupt_enable_a_r <= aea_pkg::IRQ_EN_RESET;
        end else if (reg_wr) begin
            unique case (reg_addr)
                aea_pkg::OFS_LINE_CYCLE_CONFIG: line_cycle_config_r <= reg_wdata[7:0];
                aea_pkg::OFS_HALF_CYCLE_COUNT: half_cycle_count_r <= reg_wdata[15:0]; // R05
                aea_pkg::OFS_ACCUM_MODE_SELECT: accum_mode_r <= reg_wdata[3:0]; // R22
                aea_pkg::OFS_IRQ_ENABLE_A: interrupt_enable_a_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    // update strobe for the first stage, free running from reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tick_cnt_r <= 32'h00000000;
        end else if (tick_cnt_r == 32'(UPDATE_CYCLES - 1)) begin
            tick_cnt_r <= 32'h00000000; // R21
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h00000001;
        end
    end
    assign tick = (tick_cnt_r == 32'(UPDATE_CYCLES - 1));

    // period boundary counted in voltage zero crossings; a count of zero acts as one
    assign zx_count_nxt = zx_count_r + 16'h0001;
    assign period_end = any_en && zx_pulse && (zx_count_nxt >= active_count_r); // R03 R06

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            zx_count_r <= 16'h0000;
            active_count_r <= aea_pkg::HCC_RESET;
        end else if (!any_en) begin
            // first period after enable starts off a crossing: software discards it
            zx_count_r <= 16'h0000;
            active_count_r <= half_cycle_count_r;
        end else if (period_end) begin
            zx_count_r <= 16'h0000; // R09
            active_count_r <= half_cycle_count_r; // R12
        end else if (zx_pulse) begin
            zx_count_r <= zx_count_nxt;
        end
    end

    // status flag: period end wins over the clearing read
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            period_done_flag_r <= 1'b0;
        end else if (period_end) begin
            period_done_flag_r <= 1'b1; // R07
        end else if (reg_rd && (reg_addr == aea_pkg::OFS_IRQ_STATUS_A)) begin
            period_done_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= !(period_done_flag_r && interrupt_enable_a_r[aea_pkg::PERIOD_DONE_BIT]); // R08
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_chan
            logic [1:0] mode;
            assign mode = accum_mode_r[2 * gi + 1 -: 2];
            aea_chan u_chan (
                .clock(clock),
                .rst(rst),
                .tick(tick),
                .power(gi == 0 ? power_a : power_b),
                .gain(gi == 0 ? chan_a_power_gain : chan_b_power_gain),
                .mode(mode),
                .no_load(gi == 0 ? no_load_a : no_load_b),
                .pulse_up(pulse_up[gi]),
                .pulse_dn(pulse_dn[gi]),
                .power_neg(power_neg[gi])
            );

            // 24-bit wrap gives 0x7FFFFF to 0x800000 and back with no extra logic
            assign delta[gi] = pulse_up[gi] ? 24'h000001 : (pulse_dn[gi] ? 24'hFFFFFF : 24'h000000); // R19

            // live sum: the register itself in free mode, the running period in line-cycle mode
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    live_r[gi] <= 24'h000000;
                end else if (cyc_en[gi] && period_end) begin
                    live_r[gi] <= 24'h000000; // R09
                end else if (!cyc_en[gi] && rd_energy[gi] && clr_on_read) begin
                    live_r[gi] <= delta[gi]; // R20
                end else begin
                    live_r[gi] <= live_r[gi] + delta[gi]; // R02 R19
                end
            end

            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    result_r[gi] <= 24'h000000;
                end else if (cyc_en[gi] && period_end) begin
                    result_r[gi] <= live_r[gi] + delta[gi]; // R07 R10
                end else if (rd_energy[gi] && clr_on_read) begin
                    result_r[gi] <= 24'h000000; // R11
                end
            end

            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    energy_pulse_out[gi] <= 1'b0;
                    reverse_power_en[gi] <= 1'b1;
                end else begin
                    energy_pulse_out[gi] <= pulse_up[gi] || pulse_dn[gi]; // R17
                    reverse_power_en[gi] <= (mode == aea_pkg::MODE_SIGNED) || (mode == 2'h3); // R18
                end
            end

            property p_wrap_up;
                @(posedge clock) disable iff (rst)
                !cyc_en[gi] && live_r[gi] == aea_pkg::ENERGY_MAX && pulse_up[gi] && !rd_energy[gi]
                    |=> live_r[gi] == aea_pkg::ENERGY_MIN;
            endproperty
            a_wrap_up: assert property (p_wrap_up) else $error("energy did not wrap upward"); // R19

            property p_wrap_down;
                @(posedge clock) disable iff (rst)
                !cyc_en[gi] && live_r[gi] == aea_pkg::ENERGY_MIN && pulse_dn[gi] && !rd_energy[gi]
                    |=> live_r[gi] == aea_pkg::ENERGY_MAX;
            endproperty
            a_wrap_down: assert property (p_wrap_down) else $error("energy did not wrap downward"); // R19

            property p_period_load;
                @(posedge clock) disable iff (rst)
                cyc_en[gi] && period_end |=> result_r[gi] == $past(live_r[gi]) + $past(delta[gi])
                    && period_done_flag_r;
            endproperty
            a_period_load: assert property (p_period_load) else $error("period end did not load result"); // R07

            property p_hold;
                @(posedge clock) disable iff (rst)
                cyc_en[gi] && !period_end && !rd_energy[gi] |=> $stable(result_r[gi]);
            endproperty
            a_hold: assert property (p_hold) else $error("result changed mid period"); // R10

            property p_clear_read;
                @(posedge clock) disable iff (rst)
                cyc_en[gi] && clr_on_read && rd_energy[gi] && !period_end
                    |=> result_r[gi] == 24'h000000;
            endproperty
            a_clear_read: assert property (p_clear_read) else $error("read did not clear result"); // R11

            property p_revp_off;
                @(posedge clock) disable iff (rst)
                (mode == aea_pkg::MODE_POSITIVE || mode == aea_pkg::MODE_ABSOLUTE) ##1 $stable(mode)
                    |-> !reverse_power_en[gi];
            endproperty
            a_revp_off: assert property (p_revp_off) else $error("reverse power left on"); // R18
        end
    endgenerate

    always_comb begin
        rdata_nxt = 24'h000000;
        unique case (reg_addr)
            aea_pkg::OFS_LINE_CYCLE_CONFIG: rdata_nxt = {16'h0000, line_cycle_config_r};
            aea_pkg::OFS_HALF_CYCLE_COUNT: rdata_nxt = {8'h00, half_cycle_count_r};
            aea_pkg::OFS_ACCUM_MODE_SELECT: begin
                rdata_nxt[3:0] = accum_mode_r;
                rdata_nxt[aea_pkg::SIGN_A_BIT] = power_neg[0];
                rdata_nxt[aea_pkg::SIGN_B_BIT] = power_neg[1];
            end
            aea_pkg::OFS_ENERGY_A: rdata_nxt = cyc_en[0] ? result_r[0] : live_r[0];
            aea_pkg::OFS_ENERGY_B: rdata_nxt = cyc_en[1] ? result_r[1] : live_r[1];
            aea_pkg::OFS_IRQ_ENABLE_A: rdata_nxt = interrupt_enable_a_r;
            aea_pkg::OFS_IRQ_STATUS_A: rdata_nxt[aea_pkg::PERIOD_DONE_BIT] = period_done_flag_r;
            default: rdata_nxt = 24'h000000;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= 24'h000000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_nxt;
            end
        end
    end

    property p_tick_spacing;
        @(posedge clock) disable iff (rst)
        tick |=> !tick [*8];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("update strobes too close"); // R21

    property p_irq;
        @(posedge clock) disable iff (rst)
        period_done_flag_r && interrupt_enable_a_r[aea_pkg::PERIOD_DONE_BIT] |=> !irq_n;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not asserted"); // R08

    property p_count_reload;
        @(posedge clock) disable iff (rst)
        $changed(active_count_r) |-> $past(period_end) || !$past(any_en);
    endproperty
    a_count_reload: assert property (p_count_reload) else $error("count loaded mid period"); // R12

    property p_restart;
        @(posedge clock) disable iff (rst)
        period_end |=> zx_count_r == 16'h0000;
    endproperty
    a_restart: assert property (p_restart) else $error("new period did not start"); // R09
endmodule

// ### testbench/aea_top_tb.sv
/*
 self-checking bench for aea_top: reset values, signed, positive-only and
 absolute accumulation, clear-on-read, line-cycle periods and the interrupt.
 assumes aea_pkg is compiled first; design assertions live in the design files.
*/
`timescale 1ns/1ps
module aea_top_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [9:0] reg_addr = 10'h000;
    logic [23:0] reg_wdata = 24'h000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [23:0] reg_rdata;
    logic reg_rvalid;
    logic zx_pulse = 1'b0;
    logic signed [23:0] power_a = 24'h000000;
    logic signed [23:0] power_b = 24'h000000;
    logic signed [23:0] gain_a = aea_pkg::GAIN_UNITY;
    logic signed [23:0] gain_b = aea_pkg::GAIN_UNITY;
    logic no_load_a = 1'b1;
    logic no_load_b = 1'b1;
    logic irq_n;
    logic [1:0] energy_pulse_out;
    logic [1:0] reverse_power_en;
    int n_fail = 0;
    int n_checks = 0;
    int cnt_a = 0;
    int cnt_b = 0;
    logic [31:0] seed = 32'hA0C66226;
    logic [23:0] exp_q[$];
    logic [23:0] mask_q[$];
    logic [23:0] e;
    logic [23:0] m;
    logic [23:0] pa;
    logic [23:0] pb;

    // small update period keeps each run short
    aea_top #(.UPDATE_CYCLES(50)) u_aea_top (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .zx_pulse(zx_pulse), .power_a(power_a), .power_b(power_b),
        .chan_a_power_gain(gain_a), .chan_b_power_gain(gain_b), .no_load_a(no_load_a),
        .no_load_b(no_load_b), .irq_n(irq_n), .energy_pulse_out(energy_pulse_out),
        .reverse_power_en(reverse_power_en));

    always #2.5 clock = ~clock;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic wr(input logic [9:0] a, input logic [23:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, input logic [23:0] ex, input logic [23:0] mk);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        exp_q.push_back(ex);
        mask_q.push_back(mk);
        @(negedge clock);
        reg_rd = 1'b0;
    endtask

    // magnitude kept above the threshold so every run produces pulses
    task automatic rand_power();
        seed = lfsr(seed);
        pa = 24'(seed[21:0]) | 24'h040000;
        seed = lfsr(seed);
        pb = 24'(seed[21:0]) | 24'h040000;
    endtask

    // remainder left in the first stage stays below one pulse once loads go idle
    task automatic run(input logic [23:0] a, input logic [23:0] b);
        @(posedge clock);
        cnt_a = 0;
        cnt_b = 0;
        @(negedge clock);
        power_a = a;
        power_b = b;
        no_load_a = 1'b0;
        no_load_b = 1'b0;
        repeat (300) @(negedge clock);
        no_load_a = 1'b1;
        no_load_b = 1'b1;
        repeat (100) @(negedge clock);
    endtask

    task automatic zx(input int k);
        repeat (k) begin
            repeat (100) @(negedge clock);
            zx_pulse = 1'b1;
            @(negedge clock);
            zx_pulse = 1'b0;
        end
        repeat (5) @(negedge clock);
    endtask

    always @(negedge clock) begin
        cnt_a += int'(energy_pulse_out[0]);
        cnt_b += int'(energy_pulse_out[1]);
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected read answer", 24'h000000, 24'hFFFFFF);
            end else begin
                e = exp_q.pop_front();
                m = mask_q.pop_front();
                check("read data", e & m, reg_rdata & m);
            end
        end
    end

    initial begin
        #400000;
        n_fail++;
        end_of_test();
    end

    initial begin
        repeat (6) @(negedge clock);
        rst = 1'b0;
        check("irq after reset", 24'(1'b1), 24'(irq_n));
        check("reverse enable after reset", 24'(2'b11), 24'(reverse_power_en));
        rd(aea_pkg::OFS_LINE_CYCLE_CONFIG, 24'h000040, 24'hFFFFFF);
        rd(aea_pkg::OFS_HALF_CYCLE_COUNT, 24'h0000FF, 24'hFFFFFF);
        rd(aea_pkg::OFS_ACCUM_MODE_SELECT, 24'h000000, 24'h00000F);
        rd(aea_pkg::OFS_IRQ_ENABLE_A, 24'h000000, 24'hFFFFFF);
        rd(10'h3FF, 24'h000000, 24'hFFFFFF);
        rand_power();
        run(pa, -pb);
        check("pulses a seen", 24'(1'b1), 24'(cnt_a > 0));
        rd(aea_pkg::OFS_ENERGY_A, 24'(cnt_a), 24'hFFFFFF);
        rd(aea_pkg::OFS_ENERGY_B, 24'(-cnt_b), 24'hFFFFFF);
        rd(aea_pkg::OFS_ENERGY_A, 24'h000000, 24'hFFFFFF);
        wr(aea_pkg::OFS_ACCUM_MODE_SELECT, 24'h000009);
        rd(aea_pkg::OFS_ACCUM_MODE_SELECT, 24'h000009, 24'h00000F);
        repeat (5) @(negedge clock);
        check("reverse enable", 24'(2'b00), 24'(reverse_power_en));
        rand_power();
        run(-pa, -pb);
        check("positive-only pulses", 24'h000000, 24'(cnt_a));
        check("absolute pulses seen", 24'(1'b1), 24'(cnt_b > 0));
        rd(aea_pkg::OFS_ENERGY_A, 24'h000000, 24'hFFFFFF);
        rd(aea_pkg::OFS_ENERGY_B, 24'(cnt_b), 24'hFFFFFF);
        wr(aea_pkg::OFS_ACCUM_MODE_SELECT, 24'h000000);
        // line-cycle periods: count 2, then 3 written mid-period; power flows only well inside a period
        wr(aea_pkg::OFS_IRQ_ENABLE_A, 24'h040000);
        wr(aea_pkg::OFS_HALF_CYCLE_COUNT, 24'h000002);
        wr(aea_pkg::OFS_LINE_CYCLE_CONFIG, 24'h000043);
        zx(1);
        check("irq mid period", 24'(1'b1), 24'(irq_n));
        zx(1);
        check("irq at period end", 24'(1'b0), 24'(irq_n));
        rd(aea_pkg::OFS_IRQ_STATUS_A, 24'h040000, 24'h040000);
        rd(aea_pkg::OFS_ENERGY_A, 24'h000000, 24'h000000);
        rd(aea_pkg::OFS_ENERGY_B, 24'h000000, 24'h000000);
        repeat (5) @(negedge clock);
        check("irq after status read", 24'(1'b1), 24'(irq_n));
        run(pa, -pb);
        zx(1);
        wr(aea_pkg::OFS_HALF_CYCLE_COUNT, 24'h000003);
        zx(1);
        check("irq old count", 24'(1'b0), 24'(irq_n));
        rd(aea_pkg::OFS_IRQ_STATUS_A, 24'h040000, 24'h040000);
        rd(aea_pkg::OFS_ENERGY_A, 24'(cnt_a), 24'hFFFFFF);
        rd(aea_pkg::OFS_ENERGY_B, 24'(-cnt_b), 24'hFFFFFF);
        rd(aea_pkg::OFS_ENERGY_A, 24'h000000, 24'hFFFFFF);
        // clear-on-read off: results must now survive reads
        wr(aea_pkg::OFS_LINE_CYCLE_CONFIG, 24'h000003);
        run(pa, -pb);
        rd(aea_pkg::OFS_ENERGY_B, 24'h000000, 24'hFFFFFF);
        zx(2);
        check("irq new count early", 24'(1'b1), 24'(irq_n));
        zx(1);
        check("irq new count", 24'(1'b0), 24'(irq_n));
        rd(aea_pkg::OFS_IRQ_STATUS_A, 24'h040000, 24'h040000);
        rd(aea_pkg::OFS_ENERGY_A, 24'(cnt_a), 24'hFFFFFF);
        zx(1);
        rd(aea_pkg::OFS_ENERGY_A, 24'(cnt_a), 24'hFFFFFF);
        rd(aea_pkg::OFS_ENERGY_B, 24'(-cnt_b), 24'hFFFFFF);
        wr(aea_pkg::OFS_LINE_CYCLE_CONFIG, 24'h000040);
        repeat (20) @(negedge clock);
        check("reads answered", 24'h000000, 24'(exp_q.size()));
        end_of_test();
    end
endmodule
